//--- test/ifm_cpu_model.sv
// CPU core stand-in: takes offered vectors, returns from handlers.
// Assumes the block's request output is registered on pclk.
`timescale 1ns/1ps
`default_nettype none
module ifm_cpu_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic take_en,
    input  wire logic ret_en,
    input  wire logic irq_request,
    output logic      vector_taken,
    output logic      handler_return
);
    logic [2:0] wait_q;
    // One take per request, then a short handler before returning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_taken   <= 1'b0;
            handler_return <= 1'b0;
            wait_q         <= 3'h0;
        end else begin
            vector_taken   <= take_en && irq_request && !vector_taken
                              && wait_q == 3'h0;
            handler_return <= wait_q == 3'h1;
            if (vector_taken && ret_en)
                wait_q <= 3'h5;
            else if (wait_q != 3'h0)
                wait_q <= wait_q - 3'h1;
        end
    end
endmodule
`default_nettype wire

//--- test/interrupt_flag_mask_logic_bench.sv
// Self-checking bench for the interrupt flag and mask block.
// Assumes the CPU stand-in model and an APB master run on pclk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module interrupt_flag_mask_logic_bench;
    import ifm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, pin_one, pin_zero, take_en, ret_en, clk_en;
    logic [5:0]  evt;
    logic        vector_taken, handler_return, irq_request;
    logic [3:0]  irq_vector;
    logic [3:0]  vq [$];
    int          n_fail, n_checks, cycles;
    ifm_core ifm_core_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ext_request_one(pin_one),
        .ext_request_zero(pin_zero), .wide_overflow_evt(evt[5]),
        .wide_pwm_turn_evt(evt[4]), .compare_a_evt(evt[3]),
        .compare_b_evt(evt[2]), .capture_evt(evt[1]),
        .narrow_overflow_evt(evt[0]), .vector_taken(vector_taken),
        .handler_return(handler_return), .irq_request(irq_request),
        .irq_vector(irq_vector));
    ifm_cpu_model ifm_cpu_model_i (.pclk(pclk), .presetn(presetn),
        .take_en(take_en), .ret_en(ret_en), .irq_request(irq_request),
        .vector_taken(vector_taken), .handler_return(handler_return));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Log of vectors the core accepted, plus hang guard
    always @(posedge pclk) begin
        if (vector_taken === 1'b1)
            vq.push_back(irq_vector);
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            results();
        end
    end
    // Verdict
    task automatic results();
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20)
            n_fail++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 8'h00);
        `CHK("read", x, rdat)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One-cycle timer event pulses
    task automatic ev(input logic [5:0] m);
        @(posedge pclk);
        evt <= m;
        @(posedge pclk);
        evt <= 6'h00;
    endtask
    // Reset values and an unmapped address
    task automatic t_reset();
        rd(IFM_OFS_TFLAGS, 32'h0);
        rd(IFM_OFS_TENABLE, 32'h0);
        rd(IFM_OFS_XENABLE, 32'h0);
        rd(IFM_OFS_XFLAGS, 32'h0);
        rd(IFM_OFS_CTRL, 32'h0);
        rd(8'h50, 32'h0);
        `CHK("slverr", 1'b1, rerr)
    endtask
    // Reserved bits read zero; ones on empty flags do nothing
    task automatic t_masks();
        wr(IFM_OFS_TENABLE, 8'hff);
        rd(IFM_OFS_TENABLE, 32'hea);
        wr(IFM_OFS_XENABLE, 8'hff);
        rd(IFM_OFS_XENABLE, 32'hc0);
        wr(IFM_OFS_TENABLE, 8'h00);
        wr(IFM_OFS_XENABLE, 8'h00);
        wr(IFM_OFS_TFLAGS, 8'hff);
        rd(IFM_OFS_TFLAGS, 32'h0);
    endtask
    // Low clock enable freezes the flags against an event
    task automatic t_freeze();
        clk_en <= 1'b0;
        ev(6'h02);
        clk_en <= 1'b1;
        rd(IFM_OFS_TFLAGS, 32'h0);
    endtask
    // Timer flags set while disabled, cleared by writing one
    task automatic t_flags();
        ev(6'h2f);
        rd(IFM_OFS_TFLAGS, 32'hea);
        wr(IFM_OFS_TFLAGS, 8'h80);
        rd(IFM_OFS_TFLAGS, 32'h6a);
        ev(6'h10);
        wr(IFM_OFS_CTRL, 8'h01);
        rd(IFM_OFS_TFLAGS, 32'hea);
        `CHK("irq", 1'b0, irq_request)
        wr(IFM_OFS_CTRL, 8'h00);
    endtask
    // Pending flags served one by one in vector order
    task automatic t_prio();
        logic [3:0] pv [5];
        pv = '{IFM_VEC_CAPT, IFM_VEC_CMPA, IFM_VEC_CMPB, IFM_VEC_WOVF,
               IFM_VEC_NOVF};
        wr(IFM_OFS_TENABLE, 8'hea);
        cyc(3);
        `CHK("irq", 1'b0, irq_request)
        vq.delete();
        take_en <= 1'b1;
        ret_en  <= 1'b1;
        wr(IFM_OFS_CTRL, 8'h01);
        cyc(80);
        `CHK("takes", 5, vq.size())
        for (int i = 0; i < 5; i++)
            `CHK("vector", pv[i], vq[i])
        rd(IFM_OFS_TFLAGS, 32'h0);
        rd(IFM_OFS_CTRL, 32'h1);
    endtask
    // Taking clears the global enable; software sets it again
    task automatic t_gie();
        ret_en <= 1'b0;
        vq.delete();
        ev(6'h01);
        cyc(4);
        `CHK("takes", 1, vq.size())
        rd(IFM_OFS_CTRL, 32'h0);
        ev(6'h20);
        cyc(4);
        `CHK("irq", 1'b0, irq_request)
        rd(IFM_OFS_TFLAGS, 32'h80);
        wr(IFM_OFS_CTRL, 8'h01);
        cyc(4);
        `CHK("vector", IFM_VEC_WOVF, vq[1])
        wr(IFM_OFS_TENABLE, 8'h00);
    endtask
    // Pin edges, level sensing and the reserved sense code
    task automatic t_ext();
        wr(IFM_OFS_SENSE, 8'h0e);
        pin_zero <= 1'b0;
        pin_one  <= 1'b0;
        cyc(2);
        pin_one  <= 1'b1;
        cyc(6);
        rd(IFM_OFS_XFLAGS, 32'hc0);
        vq.delete();
        ret_en <= 1'b1;
        wr(IFM_OFS_XENABLE, 8'hc0);
        wr(IFM_OFS_CTRL, 8'h01);
        cyc(40);
        `CHK("takes", 2, vq.size())
        `CHK("vector", IFM_VEC_EXT0, vq[0])
        `CHK("vector", IFM_VEC_EXT1, vq[1])
        rd(IFM_OFS_XFLAGS, 32'h0);
        take_en <= 1'b0;
        wr(IFM_OFS_SENSE, 8'h0c);
        cyc(4);
        `CHK("irq", 1'b1, irq_request)
        `CHK("vector", IFM_VEC_EXT0, irq_vector)
        rd(IFM_OFS_STATUS, 32'h8a);
        rd(IFM_OFS_SENSE, 32'hc);
        rd(IFM_OFS_XFLAGS, 32'h0);
        pin_zero <= 1'b1;
        cyc(5);
        `CHK("irq", 1'b0, irq_request)
        wr(IFM_OFS_SENSE, 8'h0d);
        pin_zero <= 1'b0;
        cyc(6);
        `CHK("irq", 1'b0, irq_request)
        rd(IFM_OFS_XFLAGS, 32'h0);
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {evt, take_en, ret_en, n_fail, n_checks, cycles} = '0;
        pin_one  = 1'b1;
        clk_en   = 1'b1;
        pin_zero = 1'b1;
        presetn  = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_masks();
        t_freeze();
        t_flags();
        t_prio();
        t_gie();
        t_ext();
        results();
    end
endmodule
`default_nettype wire

//--- verilog/ifm_core.sv
// Interrupt flag, enable and arbitration logic with an APB register port.
// Assumes the CPU core pulses vector_taken and handler_return on pclk and
// that timer event pulses come from logic on the same clock.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ifm_core
    import ifm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        ext_request_one,
    input  wire logic        ext_request_zero,
    input  wire logic        wide_overflow_evt,
    input  wire logic        wide_pwm_turn_evt,
    input  wire logic        compare_a_evt,
    input  wire logic        compare_b_evt,
    input  wire logic        capture_evt,
    input  wire logic        narrow_overflow_evt,
    input  wire logic        vector_taken,
    input  wire logic        handler_return,
    output logic             irq_request,
    output logic [3:0]       irq_vector
);
    // Register state
    logic [7:0] tflags_q;
    logic [7:0] tenable_q;
    logic [7:0] xenable_q;
    logic [7:0] xflags_q;
    logic [3:0] sense_q;
    logic       gie_q;
    logic [1:0] pin1_sync_q;
    logic [1:0] pin0_sync_q;
    logic       pin1_prev_q;
    logic       pin0_prev_q;
    logic       pready_q;
    logic [31:0] prdata_q;
    logic       pslverr_q;
    logic       irq_q;
    logic [3:0] vec_q;

    // Decoded strobes and next values
    logic       wr_acc;
    logic       rd_acc;
    logic       hit;
    logic       take;
    logic [7:0] wbyte;
    logic [1:0] sense1;
    logic [1:0] sense0;
    logic       edge1;
    logic       edge0;
    logic       lvl1;
    logic       lvl0;
    logic [7:0] tset;
    logic [7:0] tclr;
    logic [7:0] xset;
    logic [7:0] xclr;
    logic [3:0] win_d;
    logic [31:0] rdata_d;

    // APB access phase; one wait state so the answer comes from a flop
    assign wr_acc = psel && penable && pwrite && pready_q;
    assign rd_acc = psel && penable && !pwrite;
    assign wbyte  = pwdata[7:0];
    assign take   = clk_en && vector_taken && irq_q;
    assign sense1 = sense_q[3:2];
    assign sense0 = sense_q[1:0];

    // Pin synchronisers; second stage is the first one logic reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin1_sync_q <= 2'h3;
            pin0_sync_q <= 2'h3;
            pin1_prev_q <= 1'b1;
            pin0_prev_q <= 1'b1;
        end else if (clk_en) begin
            pin1_sync_q <= {pin1_sync_q[0], ext_request_one};
            pin0_sync_q <= {pin0_sync_q[0], ext_request_zero};
            pin1_prev_q <= pin1_sync_q[1];
            pin0_prev_q <= pin0_sync_q[1];
        end
    end

    // Edge and level detection per sense selection
    always_comb begin
        edge1 = 1'b0;
        edge0 = 1'b0;
        unique case (sense1)
            IFM_SENSE_FALL: edge1 = pin1_prev_q && !pin1_sync_q[1];
            IFM_SENSE_RISE: edge1 = !pin1_prev_q && pin1_sync_q[1];
            default:        edge1 = 1'b0;
        endcase
        unique case (sense0)
            IFM_SENSE_FALL: edge0 = pin0_prev_q && !pin0_sync_q[1];
            IFM_SENSE_RISE: edge0 = !pin0_prev_q && pin0_sync_q[1];
            default:        edge0 = 1'b0;
        endcase
    end
    assign lvl1 = (sense1 == IFM_SENSE_LOW) && !pin1_sync_q[1];
    assign lvl0 = (sense0 == IFM_SENSE_LOW) && !pin0_sync_q[1];

    // Priority winner among enabled pending sources
    always_comb begin
        win_d = IFM_VEC_NONE;
        if (gie_q) begin
            if (xenable_q[IFM_B_EXT0] &&
                (xflags_q[IFM_B_EXT0] || lvl0))
                win_d = IFM_VEC_EXT0;
            else if (xenable_q[IFM_B_EXT1] &&
                     (xflags_q[IFM_B_EXT1] || lvl1))
                win_d = IFM_VEC_EXT1;
            else if (tenable_q[IFM_B_CAPT] && tflags_q[IFM_B_CAPT])
                win_d = IFM_VEC_CAPT;
            else if (tenable_q[IFM_B_CMPA] && tflags_q[IFM_B_CMPA])
                win_d = IFM_VEC_CMPA;
            else if (tenable_q[IFM_B_CMPB] && tflags_q[IFM_B_CMPB])
                win_d = IFM_VEC_CMPB;
            else if (tenable_q[IFM_B_WOVF] && tflags_q[IFM_B_WOVF])
                win_d = IFM_VEC_WOVF;
            else if (tenable_q[IFM_B_NOVF] && tflags_q[IFM_B_NOVF])
                win_d = IFM_VEC_NOVF;
        end
    end

    // Set and clear terms for flags; set wins over clear
    always_comb begin
        tset = IFM_RESET8;
        tset[IFM_B_WOVF] = wide_overflow_evt || wide_pwm_turn_evt;
        tset[IFM_B_CMPA] = compare_a_evt;
        tset[IFM_B_CMPB] = compare_b_evt;
        tset[IFM_B_CAPT] = capture_evt;
        tset[IFM_B_NOVF] = narrow_overflow_evt;
        tclr = IFM_RESET8;
        xclr = IFM_RESET8;
        if (wr_acc && paddr == IFM_OFS_TFLAGS)
            tclr = wbyte & IFM_TMASK;
        if (wr_acc && paddr == IFM_OFS_XFLAGS)
            xclr = wbyte & IFM_XMASK;
        if (take) begin
            unique case (vec_q)
                IFM_VEC_EXT0: xclr[IFM_B_EXT0] = 1'b1;
                IFM_VEC_EXT1: xclr[IFM_B_EXT1] = 1'b1;
                IFM_VEC_CAPT: tclr[IFM_B_CAPT] = 1'b1;
                IFM_VEC_CMPA: tclr[IFM_B_CMPA] = 1'b1;
                IFM_VEC_CMPB: tclr[IFM_B_CMPB] = 1'b1;
                IFM_VEC_WOVF: tclr[IFM_B_WOVF] = 1'b1;
                IFM_VEC_NOVF: tclr[IFM_B_NOVF] = 1'b1;
                default:      tclr = tclr;
            endcase
        end
        xset = IFM_RESET8;
        xset[IFM_B_EXT1] = edge1;
        xset[IFM_B_EXT0] = edge0;
    end

    // Timer flags: event pulses set, regardless of enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tflags_q <= IFM_RESET8;
        else if (clk_en)
            tflags_q <= ((tflags_q & ~tclr) | tset) & IFM_TMASK;
    end

    // External flags; forced clear under level sensing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xflags_q <= IFM_RESET8;
        end else if (clk_en) begin
            xflags_q <= ((xflags_q & ~xclr) | xset) & IFM_XMASK;
            if (sense1 == IFM_SENSE_LOW)
                xflags_q[IFM_B_EXT1] <= 1'b0;
            if (sense0 == IFM_SENSE_LOW)
                xflags_q[IFM_B_EXT0] <= 1'b0;
        end
    end

    // Writable enable and sense registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tenable_q <= IFM_RESET8;
            xenable_q <= IFM_RESET8;
            sense_q   <= 4'h0;
        end else if (clk_en && wr_acc) begin
            if (paddr == IFM_OFS_TENABLE)
                tenable_q <= wbyte & IFM_TMASK;
            if (paddr == IFM_OFS_XENABLE)
                xenable_q <= wbyte & IFM_XMASK;
            if (paddr == IFM_OFS_SENSE)
                sense_q <= wbyte[3:0];
        end
    end

    // Global enable: vectoring clears, return or software sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gie_q <= 1'b0;
        else if (clk_en) begin
            if (take)
                gie_q <= 1'b0;
            else if (handler_return)
                gie_q <= 1'b1;
            else if (wr_acc && paddr == IFM_OFS_CTRL)
                gie_q <= wbyte[0];
        end
    end

    // Registered request to the core; dropped in the taking cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            vec_q <= IFM_VEC_NONE;
        end else if (clk_en) begin
            irq_q <= (win_d != IFM_VEC_NONE) && !take;
            vec_q <= take ? IFM_VEC_NONE : win_d;
        end
    end

    // Read mux
    assign hit = (paddr == IFM_OFS_TFLAGS) || (paddr == IFM_OFS_TENABLE) ||
                 (paddr == IFM_OFS_XENABLE) || (paddr == IFM_OFS_XFLAGS) ||
                 (paddr == IFM_OFS_SENSE) || (paddr == IFM_OFS_CTRL) ||
                 (paddr == IFM_OFS_STATUS);
    always_comb begin
        rdata_d = 32'h0;
        unique case (paddr)
            IFM_OFS_TFLAGS:  rdata_d[7:0] = tflags_q;
            IFM_OFS_TENABLE: rdata_d[7:0] = tenable_q;
            IFM_OFS_XENABLE: rdata_d[7:0] = xenable_q;
            IFM_OFS_XFLAGS:  rdata_d[7:0] = xflags_q;
            IFM_OFS_SENSE:   rdata_d[3:0] = sense_q;
            IFM_OFS_CTRL:    rdata_d[0]   = gie_q;
            IFM_OFS_STATUS:  rdata_d[7:0] = {irq_q, vec_q, 1'b0,
                                             pin1_sync_q[1], pin0_sync_q[1]};
            default:         rdata_d = 32'h0;
        endcase
    end

    // APB answer: pready one cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !hit;
            if (rd_acc && !pready_q)
                prdata_q <= rdata_d;
        end
    end

    assign pready      = pready_q;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q;
    assign irq_request = irq_q;
    assign irq_vector  = vec_q;

    // Assertions
    chk_take_clears_gie: assert property (@(posedge pclk)
        disable iff (!presetn) take |=> !gie_q)
        else $error("global enable not cleared");
    chk_return_sets_gie: assert property (@(posedge pclk)
        disable iff (!presetn) clk_en && !take && handler_return |=> gie_q)
        else $error("return did not set enable");
    chk_irq_needs_gie: assert property (@(posedge pclk)
        disable iff (!presetn) irq_q |-> $past(gie_q))
        else $error("request without enable");
    chk_taken_flag_clr: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && vec_q == IFM_VEC_CMPA && !compare_a_evt
        |=> !tflags_q[IFM_B_CMPA]) else $error("flag not cleared");
    chk_evt_sets_flag: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && capture_evt |=> tflags_q[IFM_B_CAPT])
        else $error("capture flag not set");
    chk_reserved_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        (tflags_q & ~IFM_TMASK) == 8'h00 && (xflags_q & ~IFM_XMASK) == 8'h00)
        else $error("reserved flag bit set");
    chk_level_no_flag: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && sense0 == IFM_SENSE_LOW |=> !xflags_q[IFM_B_EXT0])
        else $error("level flag set");
    chk_ext0_priority: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && !take && gie_q && xenable_q[IFM_B_EXT0]
        && xflags_q[IFM_B_EXT0] |=> vec_q == IFM_VEC_EXT0)
        else $error("priority wrong");
    chk_apb_answer: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && psel && penable && !pready_q |=> pready_q)
        else $error("no apb answer");

    // Named steps: a pin fall seen past the synchroniser, a take
    sequence s_pin0_fall;
        clk_en && sense0 == IFM_SENSE_FALL && pin0_sync_q[1]
        ##1 clk_en && sense0 == IFM_SENSE_FALL && !pin0_sync_q[1];
    endsequence
    sequence s_take_novf;
        take && vec_q == IFM_VEC_NOVF && !narrow_overflow_evt;
    endsequence
    sequence s_after_take;
        !gie_q && !irq_q;
    endsequence
    chk_take_quiets: assert property (@(posedge pclk)
        disable iff (!presetn) take |=> s_after_take)
        else $error("request held after take");
    chk_novf_cleared: assert property (@(posedge pclk)
        disable iff (!presetn) s_take_novf |=> !tflags_q[IFM_B_NOVF])
        else $error("overflow flag not cleared");
    chk_fall_sets_flag: assert property (@(posedge pclk)
        disable iff (!presetn) s_pin0_fall |=> xflags_q[IFM_B_EXT0])
        else $error("falling edge flag not set");
    chk_level_request: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && !take && gie_q && xenable_q[IFM_B_EXT0] && lvl0
        |=> irq_q && vec_q == IFM_VEC_EXT0)
        else $error("level request not raised");
    chk_one_clears: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && wr_acc && paddr == IFM_OFS_TFLAGS && wbyte[IFM_B_WOVF]
        && !wide_overflow_evt && !wide_pwm_turn_evt
        |=> !tflags_q[IFM_B_WOVF])
        else $error("write one did not clear");
    chk_zero_keeps: assert property (@(posedge pclk)
        disable iff (!presetn)
        clk_en && !take && wr_acc && paddr == IFM_OFS_TFLAGS
        && !wbyte[IFM_B_CMPA] && tflags_q[IFM_B_CMPA]
        |=> tflags_q[IFM_B_CMPA])
        else $error("write zero cleared a flag");
endmodule
`default_nettype wire

//--- verilog/ifm_pkg.sv
// Package for the interrupt flag and mask block: offsets, fields, vectors.
// Assumes a 32-bit APB bus; byte address is four times the register index.
package ifm_pkg;
    // Register indices, one aligned word each
    localparam logic [5:0] IFM_IDX_TFLAGS  = 6'h38;
    localparam logic [5:0] IFM_IDX_TENABLE = 6'h39;
    localparam logic [5:0] IFM_IDX_XENABLE = 6'h3a;
    localparam logic [5:0] IFM_IDX_XFLAGS  = 6'h3b;
    localparam logic [5:0] IFM_IDX_SENSE   = 6'h3c;
    localparam logic [5:0] IFM_IDX_CTRL    = 6'h3d;
    localparam logic [5:0] IFM_IDX_STATUS  = 6'h3e;
    // Register byte addresses on the bus
    localparam logic [7:0] IFM_OFS_TFLAGS  = {IFM_IDX_TFLAGS, 2'h0};
    localparam logic [7:0] IFM_OFS_TENABLE = {IFM_IDX_TENABLE, 2'h0};
    localparam logic [7:0] IFM_OFS_XENABLE = {IFM_IDX_XENABLE, 2'h0};
    localparam logic [7:0] IFM_OFS_XFLAGS  = {IFM_IDX_XFLAGS, 2'h0};
    localparam logic [7:0] IFM_OFS_SENSE   = {IFM_IDX_SENSE, 2'h0};
    localparam logic [7:0] IFM_OFS_CTRL    = {IFM_IDX_CTRL, 2'h0};
    localparam logic [7:0] IFM_OFS_STATUS  = {IFM_IDX_STATUS, 2'h0};
    // Writable and readable bit masks
    localparam logic [7:0] IFM_TMASK       = 8'hea;
    localparam logic [7:0] IFM_XMASK       = 8'hc0;
    localparam logic [7:0] IFM_RESET8      = 8'h00;
    // Field positions
    localparam int IFM_B_WOVF = 7;
    localparam int IFM_B_CMPA = 6;
    localparam int IFM_B_CMPB = 5;
    localparam int IFM_B_CAPT = 3;
    localparam int IFM_B_NOVF = 1;
    localparam int IFM_B_EXT1 = 7;
    localparam int IFM_B_EXT0 = 6;
    // Sense codes
    localparam logic [1:0] IFM_SENSE_LOW  = 2'h0;
    localparam logic [1:0] IFM_SENSE_FALL = 2'h2;
    localparam logic [1:0] IFM_SENSE_RISE = 2'h3;
    // Vector addresses, lower wins
    localparam logic [3:0] IFM_VEC_NONE = 4'h0;
    localparam logic [3:0] IFM_VEC_EXT0 = 4'h1;
    localparam logic [3:0] IFM_VEC_EXT1 = 4'h2;
    localparam logic [3:0] IFM_VEC_CAPT = 4'h3;
    localparam logic [3:0] IFM_VEC_CMPA = 4'h4;
    localparam logic [3:0] IFM_VEC_CMPB = 4'h5;
    localparam logic [3:0] IFM_VEC_WOVF = 4'h6;
    localparam logic [3:0] IFM_VEC_NOVF = 4'h7;
endpackage
